// ---- src/cab_pkg.sv ----
// Package for the core addressing and break control block.
// Assumes one core clock and a synchronous active-low core reset.
package cab_pkg;

  // Register indexes on the plain register port (byte address = index * 4)
  localparam logic [3:0] REG_STATUS = 4'h0;
  localparam logic [3:0] REG_BSTATUS = 4'h1;
  localparam logic [3:0] REG_BRKRET = 4'h2;
  localparam logic [3:0] REG_SCRATCH = 4'h3;
  localparam logic [3:0] REG_STATE = 4'h4;

  // Field positions and reset values
  localparam int STATUS_IE_BIT = 0;
  localparam logic [31:0] STATUS_RESET = 32'h0000_0000;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
  localparam int STATE_RUN_BIT = 0;
  localparam int STATE_BRK_BIT = 1;
  localparam logic [4:0] ZERO_REG_IDX = 5'h00;

  // Build-time addresses (arbitrary defaults)
  localparam logic [31:0] RESET_ADDR = 32'h0000_0000;
  localparam logic [31:0] BREAK_HANDLER_ADDR = 32'h0000_0020;
  localparam logic [31:0] EXCEPTION_ADDR = 32'h0000_0040;

  // Access sizes
  localparam logic [1:0] SIZE_BYTE = 2'h0;
  localparam logic [1:0] SIZE_HALF = 2'h1;
  localparam logic [1:0] SIZE_WORD = 2'h2;

  // Operations handed over by the decoder, one-hot
  typedef enum logic [6:0] {
    OP_ALU = 7'h01,
    OP_LOAD = 7'h02,
    OP_STORE = 7'h04,
    OP_BREAK = 7'h08,
    OP_BRKRET = 7'h10,
    OP_CACHE_INIT = 7'h20,
    OP_CACHE_FLUSH = 7'h40
  } cab_op_t;

  // Control sequencer states, one-hot
  typedef enum logic [2:0] {
    ST_RST = 3'h1,
    ST_INV = 3'h2,
    ST_RUN = 3'h4
  } cab_state_t;

  // One decoded instruction
  typedef struct packed {
    logic valid;
    cab_op_t op;
    logic [1:0] size;
    logic unsignedLoad;
    logic ioAccess;
    logic useImm;
    logic immSigned;
    logic [4:0] baseIdx;
    logic [31:0] baseVal;
    logic [31:0] operandReg;
    logic [15:0] imm16;
    logic [31:0] storeData;
    logic [31:0] nextPc;
  } cab_exec_t;

  // One data bus request
  typedef struct packed {
    logic valid;
    logic write;
    logic bypass;
    logic [31:0] addr;
    logic [3:0] byteEn;
    logic [31:0] wdata;
  } cab_mem_t;

endpackage : cab_pkg

// ---- src/cab_core_ctrl.sv ----
// Break entry and return, status register, data addressing and reset sequencing.
// Assumes a decoder feeding one-cycle exec pulses and a 32-bit data bus outside.
//
// Our own choices: the address-and-strobe port and the address map.
`timescale 1ns/100ps
module cab_core_ctrl #(
  parameter int ADDR_BITS = 32,
  parameter bit BIT31_BYPASS = 1'b0,
  parameter bit HAS_CACHE = 1'b1
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Register port
  input wire logic [3:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdata,
  // Decoded instruction and pins
  input wire cab_pkg::cab_exec_t exec,
  input wire logic brkPin,
  input wire logic irqPin,
  // Fetch redirect
  output logic fetchValid,
  output logic [31:0] fetchAddr,
  output logic irqTake,
  // Cache control
  output logic icInvValid,
  output logic [31:0] icInvAddr,
  output logic cacheOpValid,
  output logic cacheOpFlush,
  // Data bus
  output cab_pkg::cab_mem_t memReq,
  input wire logic memRvalid,
  input wire logic [31:0] memRdata,
  output logic loadValid,
  output logic [31:0] loadData,
  // Execute operand
  output logic [31:0] aluOperandB
);

  localparam int EFF_BITS = (BIT31_BYPASS && ADDR_BITS > 31) ? 31 : ADDR_BITS;
  localparam logic [32:0] MASK_WIDE = (33'h1 << EFF_BITS) - 33'h1;

  cab_pkg::cab_state_t state_reg, state_next;
  logic [31:0] status_reg, bstatus_reg, brkRet_reg, scratch_reg;
  logic inBreak_reg;
  logic brkMeta_reg, brkSync_reg, irqMeta_reg, irqSync_reg;
  logic [1:0] ldLow_reg, ldSize_reg;
  logic ldUns_reg;

  // Decode of the incoming instruction
  wire running = (state_reg == cab_pkg::ST_RUN);
  wire execGo = running && exec.valid;
  wire doBreak = running && ((execGo && exec.op == cab_pkg::OP_BREAK) || brkSync_reg);
  wire doBret = !doBreak && execGo && exec.op == cab_pkg::OP_BRKRET;
  wire doIrq = running && !doBreak && !doBret && !inBreak_reg && irqSync_reg
    && status_reg[cab_pkg::STATUS_IE_BIT];
  wire doLoad = execGo && !doBreak && exec.op == cab_pkg::OP_LOAD;
  wire doStore = execGo && !doBreak && exec.op == cab_pkg::OP_STORE;
  wire doCache = execGo && !doBreak && HAS_CACHE
    && (exec.op == cab_pkg::OP_CACHE_INIT || exec.op == cab_pkg::OP_CACHE_FLUSH);
  wire [31:0] brkRetSrc = (execGo && exec.op == cab_pkg::OP_BREAK) ? exec.nextPc : fetchAddr;

  // Effective address and data lanes
  wire [31:0] immSext = {{16{exec.imm16[15]}}, exec.imm16};
  wire [31:0] immZext = {16'h0000, exec.imm16};
  wire [31:0] baseEff = (exec.baseIdx == cab_pkg::ZERO_REG_IDX) ? cab_pkg::WORD_ZERO
    : exec.baseVal;
  wire [31:0] effAddr = baseEff + immSext;
  wire [31:0] addrMask = MASK_WIDE[31:0];
  wire bypassSel = exec.ioAccess || (BIT31_BYPASS && effAddr[31]);
  wire isByte = (exec.size == cab_pkg::SIZE_BYTE);
  wire isHalf = (exec.size == cab_pkg::SIZE_HALF);
  wire [3:0] byteEnSel = isByte ? (4'h1 << effAddr[1:0])
    : isHalf ? (effAddr[1] ? 4'hC : 4'h3) : 4'hF;
  wire [31:0] wdataSel = isByte ? {4{exec.storeData[7:0]}}
    : isHalf ? {2{exec.storeData[15:0]}} : exec.storeData;
  wire [31:0] laneShift = memRdata >> {ldLow_reg, 3'h0};
  wire [31:0] loadExt = (ldSize_reg == cab_pkg::SIZE_BYTE)
    ? {{24{!ldUns_reg && laneShift[7]}}, laneShift[7:0]}
    : (ldSize_reg == cab_pkg::SIZE_HALF)
    ? {{16{!ldUns_reg && laneShift[15]}}, laneShift[15:0]} : memRdata;

  // Operand select for register and immediate modes
  assign aluOperandB = !exec.useImm ? exec.operandReg
    : exec.immSigned ? immSext : immZext;

  // Register port decode
  wire wrStatus = regWr && regAddr == cab_pkg::REG_STATUS;
  wire wrBstatus = regWr && regAddr == cab_pkg::REG_BSTATUS;
  wire wrBrkRet = regWr && regAddr == cab_pkg::REG_BRKRET;
  wire wrScratch = regWr && regAddr == cab_pkg::REG_SCRATCH;
  wire [31:0] stateWord = {30'h0, inBreak_reg, running};
  wire [31:0] rdSel = (regAddr == cab_pkg::REG_STATUS) ? status_reg
    : (regAddr == cab_pkg::REG_BSTATUS) ? bstatus_reg
    : (regAddr == cab_pkg::REG_BRKRET) ? brkRet_reg
    : (regAddr == cab_pkg::REG_SCRATCH) ? scratch_reg
    : (regAddr == cab_pkg::REG_STATE) ? stateWord : cab_pkg::WORD_ZERO;

  // Pin synchronisers
  always_ff @(posedge mclk) begin
    brkMeta_reg <= rstn && brkPin;
    brkSync_reg <= rstn && brkMeta_reg;
    irqMeta_reg <= rstn && irqPin;
    irqSync_reg <= rstn && irqMeta_reg;
  end

  // Reset sequencer: invalidate reset line, then first fetch
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      cab_pkg::ST_RST: state_next = cab_pkg::ST_INV;
      cab_pkg::ST_INV: state_next = cab_pkg::ST_RUN;
      cab_pkg::ST_RUN: state_next = cab_pkg::ST_RUN;
      default: state_next = cab_pkg::ST_RST;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rstn) state_reg <= cab_pkg::ST_RST;
    else state_reg <= state_next;
  end

  // Status, break save and restore; hardware wins over software
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      status_reg <= cab_pkg::STATUS_RESET;
      bstatus_reg <= cab_pkg::WORD_ZERO;
      brkRet_reg <= cab_pkg::WORD_ZERO;
      inBreak_reg <= 1'b0;
    end else if (doBreak) begin
      bstatus_reg <= status_reg;
      status_reg <= status_reg & ~(32'h1 << cab_pkg::STATUS_IE_BIT);
      brkRet_reg <= brkRetSrc;
      inBreak_reg <= 1'b1;
    end else if (doBret) begin
      status_reg <= bstatus_reg;
      inBreak_reg <= 1'b0;
    end else if (doIrq) begin
      status_reg <= status_reg & ~(32'h1 << cab_pkg::STATUS_IE_BIT);
    end else begin
      if (wrStatus) status_reg <= regWdata;
      if (wrBstatus) bstatus_reg <= regWdata;
      if (wrBrkRet) brkRet_reg <= regWdata;
    end
  end

  // Break scratch register, free for break code
  always_ff @(posedge mclk) begin
    if (!rstn) scratch_reg <= cab_pkg::WORD_ZERO;
    else if (wrScratch) scratch_reg <= regWdata;
  end

  // Register read data, valid one cycle after the strobe only
  always_ff @(posedge mclk) begin
    if (!rstn) regRdata <= cab_pkg::WORD_ZERO;
    else regRdata <= regRd ? rdSel : cab_pkg::WORD_ZERO;
  end

  // Fetch redirect and reset line invalidate
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      fetchValid <= 1'b0;
      fetchAddr <= cab_pkg::RESET_ADDR;
      irqTake <= 1'b0;
      icInvValid <= 1'b0;
      icInvAddr <= cab_pkg::RESET_ADDR;
    end else begin
      icInvValid <= (state_reg == cab_pkg::ST_RST) && HAS_CACHE;
      irqTake <= doIrq;
      fetchValid <= (state_reg == cab_pkg::ST_INV) || doBreak || doBret || doIrq;
      if (state_reg == cab_pkg::ST_INV) fetchAddr <= cab_pkg::RESET_ADDR;
      else if (doBreak) fetchAddr <= cab_pkg::BREAK_HANDLER_ADDR;
      else if (doBret) fetchAddr <= brkRet_reg;
      else if (doIrq) fetchAddr <= cab_pkg::EXCEPTION_ADDR;
      else if (execGo) fetchAddr <= exec.nextPc;
    end
  end

  // Cache management requests
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      cacheOpValid <= 1'b0;
      cacheOpFlush <= 1'b0;
    end else begin
      cacheOpValid <= doCache;
      cacheOpFlush <= doCache && exec.op == cab_pkg::OP_CACHE_FLUSH;
    end
  end

  // Data bus request; unmapped addresses get no special handling
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      memReq <= '0;
      ldLow_reg <= 2'h0;
      ldSize_reg <= cab_pkg::SIZE_WORD;
      ldUns_reg <= 1'b0;
    end else begin
      memReq.valid <= doLoad || doStore;
      memReq.write <= doStore;
      memReq.bypass <= bypassSel;
      memReq.addr <= effAddr & addrMask;
      memReq.byteEn <= byteEnSel;
      memReq.wdata <= wdataSel;
      if (doLoad) begin
        ldLow_reg <= effAddr[1:0];
        ldSize_reg <= exec.size;
        ldUns_reg <= exec.unsignedLoad;
      end
    end
  end

  // Load data alignment and extension
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      loadValid <= 1'b0;
      loadData <= cab_pkg::WORD_ZERO;
    end else begin
      loadValid <= memRvalid;
      if (memRvalid) loadData <= loadExt;
    end
  end

  // Checks
  property p_brk_save;
    @(posedge mclk) disable iff (!rstn)
    doBreak |=> bstatus_reg == $past(status_reg) && !status_reg[cab_pkg::STATUS_IE_BIT];
  endproperty
  a_brk_save: assert property (p_brk_save) else $error("break did not save status");

  property p_brk_ret_addr;
    @(posedge mclk) disable iff (!rstn)
    (execGo && exec.op == cab_pkg::OP_BREAK) |=> brkRet_reg == $past(exec.nextPc)
      && fetchValid && fetchAddr == cab_pkg::BREAK_HANDLER_ADDR;
  endproperty
  a_brk_ret_addr: assert property (p_brk_ret_addr) else $error("break return address wrong");

  property p_bret;
    @(posedge mclk) disable iff (!rstn)
    doBret |=> status_reg == $past(bstatus_reg) && fetchValid && fetchAddr == $past(brkRet_reg);
  endproperty
  a_bret: assert property (p_bret) else $error("break return did not restore");

  property p_disp_addr;
    @(posedge mclk) disable iff (!rstn)
    (doLoad || doStore) |=> memReq.valid
      && memReq.addr == (($past(baseEff) + {{16{$past(exec.imm16[15])}}, $past(exec.imm16)})
      & addrMask);
  endproperty
  a_disp_addr: assert property (p_disp_addr) else $error("effective address wrong");

  property p_zero_base;
    @(posedge mclk) disable iff (!rstn)
    exec.valid && exec.baseIdx == cab_pkg::ZERO_REG_IDX |-> effAddr == immSext;
  endproperty
  a_zero_base: assert property (p_zero_base) else $error("zero register base not zero");

  property p_half_lanes;
    @(posedge mclk) disable iff (!rstn)
    doStore && isHalf |=> memReq.byteEn == ($past(effAddr[1]) ? 4'hC : 4'h3)
      && memReq.wdata[31:16] == $past(exec.storeData[15:0]);
  endproperty
  a_half_lanes: assert property (p_half_lanes) else $error("half-word lanes wrong");

  property p_irq_gate;
    @(posedge mclk) disable iff (!rstn)
    irqTake |-> $past(status_reg[cab_pkg::STATUS_IE_BIT]) && !status_reg[cab_pkg::STATUS_IE_BIT];
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("interrupt taken while disabled");

  property p_reset_seq;
    @(posedge mclk) disable iff (!rstn)
    state_reg == cab_pkg::ST_RST |=> icInvValid == HAS_CACHE && !fetchValid
      ##1 fetchValid && fetchAddr == cab_pkg::RESET_ADDR && status_reg == cab_pkg::STATUS_RESET;
  endproperty
  a_reset_seq: assert property (p_reset_seq) else $error("reset sequence wrong");

  property p_no_cache;
    @(posedge mclk) disable iff (!rstn)
    !HAS_CACHE |-> !cacheOpValid && !icInvValid;
  endproperty
  a_no_cache: assert property (p_no_cache) else $error("cache op without cache");

  property p_bypass;
    @(posedge mclk) disable iff (!rstn)
    (doLoad || doStore) && BIT31_BYPASS |=> memReq.bypass == ($past(effAddr[31]) || $past(exec.ioAccess))
      && !memReq.addr[31];
  endproperty
  a_bypass: assert property (p_bypass) else $error("top-bit bypass wrong");

endmodule : cab_core_ctrl

// ---- tb/cab_mem_model.sv ----
// Word memory on the far side of the data bus, loads answered after LAT cycles.
// Assumes one load outstanding and addresses inside a 256-byte window.
`timescale 1ns/100ps
module cab_mem_model #(
  parameter int LAT = 2
) (
  // Clock
  input wire logic mclk,
  // Data bus
  input wire cab_pkg::cab_mem_t memReq,
  output logic memRvalid,
  output logic [31:0] memRdata
);
  logic [31:0] mem [64];
  logic [31:0] rdAddr = 32'h0;
  int cnt = 0;

  initial memRvalid = 1'b0;
  initial memRdata = 32'h0;

  // One space for code, data and peripherals; high bits alias
  always @(posedge mclk) begin
    memRvalid <= 1'b0;
    memRdata <= ~memRdata; // Idle bus inverts its data every cycle
    if (cnt > 0) cnt <= cnt - 1;
    if (memReq.valid && memReq.write) begin
      for (int i = 0; i < 4; i++) begin
        if (memReq.byteEn[i]) mem[memReq.addr[7:2]][i*8 +: 8] <= memReq.wdata[i*8 +: 8];
      end
    end else if (memReq.valid) begin
      cnt <= LAT;
      rdAddr <= memReq.addr;
    end
    if (cnt == 1) begin
      memRvalid <= 1'b1;
      memRdata <= mem[rdAddr[7:2]];
    end
  end
endmodule : cab_mem_model

// ---- tb/cab_core_ctrl_bench.sv ----
// Self-checking bench for the core addressing and break control block.
// Assumes the memory model on the data bus; a cacheless top-bit bypass core runs alongside.
`timescale 1ns/100ps
module cab_core_ctrl_bench;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic [3:0] regAddr = 4'h0;
  logic [31:0] regWdata = 32'h0;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic irqPin = 1'b0;
  logic brkPin = 1'b0;
  logic cacheOpNc, icInvNc;
  cab_pkg::cab_mem_t memReqNc;
  cab_pkg::cab_exec_t exec = '0;
  cab_pkg::cab_mem_t memReq;
  logic fetchValid, irqTake, icInvValid, cacheOpValid, cacheOpFlush, memRvalid, loadValid;
  logic [31:0] regRdata, fetchAddr, icInvAddr, memRdata, loadData, aluOperandB, rd;
  int n_mismatch = 0;
  int total_checks = 0;

  // 50 MHz core clock
  always #10 mclk = ~mclk;

  cab_core_ctrl DUT (.mclk(mclk), .rstn(rstn), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .exec(exec), .brkPin(brkPin),
    .irqPin(irqPin), .fetchValid(fetchValid), .fetchAddr(fetchAddr), .irqTake(irqTake),
    .icInvValid(icInvValid), .icInvAddr(icInvAddr), .cacheOpValid(cacheOpValid),
    .cacheOpFlush(cacheOpFlush), .memReq(memReq), .memRvalid(memRvalid),
    .memRdata(memRdata), .loadValid(loadValid), .loadData(loadData),
    .aluOperandB(aluOperandB));
  cab_mem_model MEM (.mclk(mclk), .memReq(memReq), .memRvalid(memRvalid), .memRdata(memRdata));

  // Second core: no caches, top address bit selects bypass
  cab_core_ctrl #(.ADDR_BITS(32), .BIT31_BYPASS(1'b1), .HAS_CACHE(1'b0)) DUT_NC (.mclk(mclk),
    .rstn(rstn), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(), .exec(exec), .brkPin(brkPin), .irqPin(irqPin), .fetchValid(), .fetchAddr(),
    .irqTake(), .icInvValid(icInvNc), .icInvAddr(), .cacheOpValid(cacheOpNc),
    .cacheOpFlush(), .memReq(memReqNc), .memRvalid(memRvalid), .memRdata(memRdata),
    .loadValid(), .loadData(), .aluOperandB());

  // Compare one value
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Register port write and read
  task automatic reg_w(input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge mclk);
    regWr <= 1'b0;
  endtask : reg_w

  task automatic reg_r(input logic [3:0] a, output logic [31:0] d);
    @(posedge mclk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge mclk);
    regRd <= 1'b0;
    #1 d = regRdata;
  endtask : reg_r

  // One instruction pulse; returns just after the answering edge
  task automatic run(input cab_pkg::cab_exec_t e);
    @(posedge mclk);
    exec <= e;
    @(posedge mclk);
    exec.valid <= 1'b0;
    #1;
  endtask : run

  function automatic cab_pkg::cab_exec_t mk(input cab_pkg::cab_op_t op, input logic [1:0] sz,
      input logic [31:0] base, input logic [15:0] imm, input logic [31:0] sd);
    mk = '0;
    mk.valid = 1'b1;
    mk.op = op;
    mk.size = sz;
    mk.baseIdx = 5'h01;
    mk.baseVal = base;
    mk.imm16 = imm;
    mk.storeData = sd;
  endfunction : mk

  // Reset sequence and reset state
  task automatic t_reset();
    repeat (3) @(posedge mclk);
    rstn <= 1'b1;
    @(posedge mclk);
    #1 chk(fetchValid, 32'h0);
    chk(icInvValid, 32'h1);
    chk(icInvAddr, cab_pkg::RESET_ADDR);
    chk(icInvNc, 32'h0);
    @(posedge mclk);
    #1 chk(icInvValid, 32'h0);
    chk(fetchValid, 32'h1);
    chk(fetchAddr, cab_pkg::RESET_ADDR);
    reg_r(cab_pkg::REG_STATUS, rd);
    chk(rd, cab_pkg::STATUS_RESET);
    reg_r(4'hF, rd);
    chk(rd, 32'h0);
  endtask : t_reset

  // Stores of every size through each addressing mode
  task automatic t_store();
    cab_pkg::cab_exec_t e;
    run(mk(cab_pkg::OP_STORE, cab_pkg::SIZE_WORD, 32'h0000_0100, 16'h0000, 32'h1122_3344));
    chk(memReq.addr, 32'h0000_0100);
    chk({memReq.valid, memReq.write, memReq.byteEn}, 32'h3F);
    run(mk(cab_pkg::OP_STORE, cab_pkg::SIZE_HALF, 32'h0000_0104, 16'hFFFE, 32'h0000_8001));
    chk(memReq.addr, 32'h0000_0102);
    chk(memReq.byteEn, 32'hC);
    chk(memReq.wdata, 32'h8001_8001);
    e = mk(cab_pkg::OP_STORE, cab_pkg::SIZE_BYTE, 32'h0000_5555, 16'h0101, 32'h0000_00A5);
    e.baseIdx = cab_pkg::ZERO_REG_IDX;
    run(e);
    chk(memReq.addr, 32'h0000_0101);
    chk(memReq.byteEn, 32'h2);
    chk(memReq.wdata, 32'hA5A5_A5A5);
    run(mk(cab_pkg::OP_STORE, cab_pkg::SIZE_WORD, 32'h8000_0010, 16'h0000, 32'h0));
    chk(memReq.addr, 32'h8000_0010);
    chk(memReqNc.addr, 32'h0000_0010);
    chk({memReq.bypass, memReqNc.bypass}, 32'h1);
  endtask : t_store

  // Loads back with lane shift and extension; last one uncached
  task automatic t_load();
    cab_pkg::cab_exec_t e;
    logic [31:0] ad [4] = '{32'h0000_0100, 32'h0000_0102, 32'h0000_0102, 32'h0000_0101};
    logic [31:0] ex [4] = '{32'h8001_A544, 32'hFFFF_8001, 32'h0000_8001, 32'hFFFF_FFA5};
    logic [1:0] sz [4] = '{2'h2, 2'h1, 2'h1, 2'h0}; // Word, half, half, byte
    for (int i = 0; i < 4; i++) begin
      e = mk(cab_pkg::OP_LOAD, sz[i], ad[i], 16'h0000, 32'h0);
      e.unsignedLoad = (i == 2);
      e.ioAccess = (i == 3);
      run(e);
      chk(memReq.bypass, (i == 3));
      for (int k = 0; k < 20 && loadValid !== 1'b1; k++) @(posedge mclk) #1;
      chk(loadValid, 32'h1);
      chk(loadData, ex[i]);
    end
  endtask : t_load

  // Break entry, scratch use and break return
  task automatic t_break();
    cab_pkg::cab_exec_t e;
    reg_w(cab_pkg::REG_STATUS, 32'h1);
    e = mk(cab_pkg::OP_BREAK, cab_pkg::SIZE_WORD, 32'h0, 16'h0000, 32'h0);
    e.nextPc = 32'h0000_1234;
    run(e);
    chk(fetchValid, 32'h1);
    chk(fetchAddr, cab_pkg::BREAK_HANDLER_ADDR);
    reg_r(cab_pkg::REG_BSTATUS, rd);
    chk(rd, 32'h1);
    reg_r(cab_pkg::REG_STATUS, rd);
    chk(rd, 32'h0);
    reg_r(cab_pkg::REG_BRKRET, rd);
    chk(rd, 32'h0000_1234);
    reg_w(cab_pkg::REG_SCRATCH, 32'h0000_BEEF);
    reg_r(cab_pkg::REG_SCRATCH, rd);
    chk(rd, 32'h0000_BEEF);
    e.op = cab_pkg::OP_BRKRET;
    e.nextPc = 32'h0;
    run(e);
    chk(fetchAddr, 32'h0000_1234);
    reg_r(cab_pkg::REG_STATUS, rd);
    chk(rd, 32'h1);
    // Pin break, one-cycle pulse; return address is the current fetch address
    @(posedge mclk);
    brkPin <= 1'b1;
    @(posedge mclk);
    brkPin <= 1'b0;
    for (int k = 0; k < 10 && fetchValid !== 1'b1; k++) @(posedge mclk) #1;
    chk(fetchAddr, cab_pkg::BREAK_HANDLER_ADDR);
    reg_r(cab_pkg::REG_BRKRET, rd);
    chk(rd, 32'h0000_1234);
    run(e);
    chk(fetchAddr, 32'h0000_1234);
  endtask : t_break

  // Interrupt taken while enabled, then blocked once status clears
  task automatic t_irq();
    @(posedge mclk);
    irqPin <= 1'b1;
    for (int k = 0; k < 10 && irqTake !== 1'b1; k++) @(posedge mclk) #1;
    chk(irqTake, 32'h1);
    chk(fetchAddr, cab_pkg::EXCEPTION_ADDR);
    repeat (5) begin
      @(posedge mclk);
      #1 chk(irqTake, 32'h0);
    end
    @(posedge mclk);
    irqPin <= 1'b0;
  endtask : t_irq

  // Cache init and flush pulses
  task automatic t_cache();
    for (int i = 0; i < 2; i++) begin
      run(mk(i ? cab_pkg::OP_CACHE_FLUSH : cab_pkg::OP_CACHE_INIT, 2'h2, 32'h0, 16'h0, 32'h0));
      chk({cacheOpValid, cacheOpFlush}, i ? 32'h3 : 32'h2);
      chk(cacheOpNc, 32'h0);
    end
  endtask : t_cache

  // Operand select: signed and unsigned immediate, then register
  task automatic t_operand();
    @(posedge mclk);
    exec.useImm <= 1'b1;
    exec.immSigned <= 1'b1;
    exec.imm16 <= 16'h8000;
    exec.operandReg <= 32'h0000_0077;
    #1 chk(aluOperandB, 32'hFFFF_8000);
    @(posedge mclk);
    exec.immSigned <= 1'b0;
    #1 chk(aluOperandB, 32'h0000_8000);
    @(posedge mclk);
    exec.useImm <= 1'b0;
    #1 chk(aluOperandB, 32'h0000_0077);
  endtask : t_operand

  task automatic tally_and_finish();
    $display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : tally_and_finish

  // Main sequence
  initial begin
    t_reset();
    t_store();
    t_load();
    t_break();
    t_irq();
    t_cache();
    t_operand();
    tally_and_finish();
  end

  // Watchdog, about 24 times the expected run
  initial begin
    #40000;
    n_mismatch++;
    tally_and_finish();
  end
endmodule : cab_core_ctrl_bench
